// ===== ubt_core.sv
// serial core: prescaler, baud divider, transmitter, receiver, AHB-Lite registers
// assumes hclk is the serial reference clock; rx_pin is asynchronous
//
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ubt_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic irq_pin
);
   import ubt_pkg::*;

   typedef struct packed {
      logic [7:0] interrupt_enable_reg;
      logic [7:0] line_control_reg;
      logic [7:0] modem_control_reg;
      logic [7:0] dll;
      logic [7:0] divisor_high_reg;
      logic fifo_en;
      logic [1:0] tx_trig;
      logic [1:0] rx_trig;
      logic [1:0] pre_cnt;
      logic [15:0] div_cnt;
      logic tick;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      ubt_tx_t tx_st;
      logic [3:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_pin;
      logic rx_s1;
      logic rx_s2;
      logic rx_prev;
      ubt_rx_t rx_st;
      logic [3:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      logic rx_perr;
      logic rx_one;
      logic overrun;
      logic tmo_flag;
      logic [10:0] tmo_cnt;
      logic irq_pin;
   } ubt_state_t;

   ubt_state_t s;
   ubt_state_t n;
   logic pre_tick;
   logic [15:0] div_last;
   logic [2:0] nlast;
   logic [10:0] tmo_lim;
   logic addr_ok;
   logic take_rd;
   logic take_wr;
   logic tx_full;
   logic rx_full;
   logic tx_push;
   logic tx_pop;
   logic tx_clr;
   logic rx_push;
   logic rx_pop;
   logic rx_clr;
   logic tx_edge;
   logic rx_edge;
   logic [7:0] tx_head;
   ubt_rx_entry_t rx_head;
   ubt_rx_entry_t rx_wdata;
   logic [FIFO_CW-1:0] tx_count;
   logic [FIFO_CW-1:0] rx_count;
   logic thre;
   logic temt;
   logic tmo_int;
   logic rda_int;
   logic thr_int;
   logic [7:0] line_status_reg;
   logic [7:0] interrupt_status_reg;
   logic [7:0] rd_byte;

   // ------------------------------------------------------------
   // fifos
   // ------------------------------------------------------------
   ubt_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk(hclk), .rst_n(hresetn), .clear(tx_clr), .push(tx_push), .wdata(hwdata[7:0]),
      .pop(tx_pop), .rdata(tx_head), .count(tx_count)
   );

   // entries carry three error tags beside the byte
   ubt_fifo #(.W($bits(ubt_rx_entry_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk(hclk), .rst_n(hresetn), .clear(rx_clr), .push(rx_push), .wdata(rx_wdata),
      .pop(rx_pop), .rdata(rx_head), .count(rx_count)
   );

   // ------------------------------------------------------------
   // decode and status
   // ------------------------------------------------------------
   assign pre_tick = !s.modem_control_reg[MCR_PRESCALE_BIT] || (s.pre_cnt == PRE_LAST);
   assign div_last = {s.divisor_high_reg, s.dll} - 16'h0001;
   assign nlast = DATA_LAST_MIN + {1'b0, s.line_control_reg[1:0]};
   assign tmo_lim = 11'((TMO_WORDS * (BASE_BITS + int'(s.line_control_reg[1:0])) + TMO_BITS) * BIT_TICKS);
   // bus side runs on hclk only, never on the baud tick
   assign addr_ok = hsel && hready && htrans[1] && (hsize == SIZE_WORD) && (haddr[31:8] == '0);
   assign take_rd = addr_ok && !hwrite;
   assign take_wr = addr_ok && hwrite;
   assign tx_full = s.fifo_en ? (tx_count == FIFO_CW'(FIFO_DEPTH)) : (tx_count != '0);
   assign rx_full = s.fifo_en ? (rx_count == FIFO_CW'(FIFO_DEPTH)) : (rx_count != '0);
   assign tx_push = s.wr_pend && (s.wr_addr == OFS_DATA) && !tx_full;
   assign tx_pop = (s.tx_st == TX_IDLE) && s.tick && (tx_count != '0);
   assign rx_pop = take_rd && (haddr[7:0] == OFS_DATA) && (rx_count != '0);
   assign tx_clr = s.wr_pend && (s.wr_addr == OFS_ISR_FCR)
      && (hwdata[FCR_TXCLR_BIT] || (hwdata[FCR_EN_BIT] != s.fifo_en));
   assign rx_clr = s.wr_pend && (s.wr_addr == OFS_ISR_FCR)
      && (hwdata[FCR_RXCLR_BIT] || (hwdata[FCR_EN_BIT] != s.fifo_en));
   assign tx_edge = s.tick && (s.tx_cnt == BIT_LAST);
   assign rx_edge = s.tick && (s.rx_cnt == BIT_LAST);
   assign thre = (tx_count == '0);
   assign temt = thre && (s.tx_st == TX_IDLE);
   assign tmo_int = s.interrupt_enable_reg[IER_RX_BIT] && s.tmo_flag;
   assign rda_int = s.interrupt_enable_reg[IER_RX_BIT] && (s.fifo_en ? (rx_count >= ubt_trig(s.rx_trig))
      : (rx_count != '0));
   assign thr_int = s.interrupt_enable_reg[IER_TX_BIT] && (s.fifo_en ? (tx_count < ubt_trig(s.tx_trig))
      : thre);
   assign line_status_reg = {1'b0, temt, thre, (rx_count != '0) ? {rx_head.brk, rx_head.frame, rx_head.par}
      : 3'h0, s.overrun, rx_count != '0};
   assign interrupt_status_reg = (tmo_int ? ISR_TMO : rda_int ? ISR_RDA : thr_int ? ISR_THRE : ISR_NONE)
      | (s.fifo_en ? ISR_FIFO : 8'h00);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      n = s;
      rx_push = 1'b0;
      rx_wdata = '0;
      rd_byte = 8'h00;
      n.hreadyout = 1'b1;
      n.hresp = 1'b0;
      // register writes land in the data phase
      n.wr_pend = take_wr;
      n.wr_addr = haddr[7:0];
      if (s.wr_pend)
      begin
         if (s.wr_addr == OFS_IER)
            n.interrupt_enable_reg = hwdata[7:0];
         else if (s.wr_addr == OFS_ISR_FCR)
         begin
            n.fifo_en = hwdata[FCR_EN_BIT];
            n.tx_trig = hwdata[5:4];
            n.rx_trig = hwdata[7:6];
         end
         else if (s.wr_addr == OFS_LCR)
            n.line_control_reg = hwdata[7:0];
         else if (s.wr_addr == OFS_MCR)
            n.modem_control_reg = hwdata[7:0];
         else if (s.wr_addr == OFS_DLL)
            n.dll = hwdata[7:0];
         else if (s.wr_addr == OFS_DLM)
            n.divisor_high_reg = hwdata[7:0];
      end
      // read data captured at the address phase
      if (haddr[7:0] == OFS_DATA)
         rd_byte = (rx_count != '0) ? rx_head.data : 8'h00;
      else if (haddr[7:0] == OFS_IER)
         rd_byte = s.interrupt_enable_reg;
      else if (haddr[7:0] == OFS_ISR_FCR)
         rd_byte = interrupt_status_reg;
      else if (haddr[7:0] == OFS_LCR)
         rd_byte = s.line_control_reg;
      else if (haddr[7:0] == OFS_MCR)
         rd_byte = s.modem_control_reg;
      else if (haddr[7:0] == OFS_LSR)
         rd_byte = line_status_reg;
      else if (haddr[7:0] == OFS_DLL)
         rd_byte = s.dll;
      else if (haddr[7:0] == OFS_DLM)
         rd_byte = s.divisor_high_reg;
      if (take_rd)
      begin
         n.hrdata = {24'h000000, rd_byte};
         if (haddr[7:0] == OFS_LSR)
            n.overrun = 1'b0;
      end

      // prescaler and baud divider
      n.pre_cnt = pre_tick ? 2'h0 : s.pre_cnt + 2'h1;
      n.tick = 1'b0;
      if (pre_tick)
      begin
         if (s.div_cnt >= div_last)
         begin
            n.div_cnt = 16'h0000;
            n.tick = 1'b1;
         end
         else
            n.div_cnt = s.div_cnt + 16'h0001;
      end

      // transmitter
      if (s.tx_st != TX_IDLE && s.tick)
         n.tx_cnt = s.tx_cnt + 4'h1;
      case (s.tx_st)
         TX_IDLE:
            if (tx_pop)
            begin
               n.tx_sh = tx_head;
               n.tx_st = TX_START;
               n.tx_cnt = 4'h0;
               n.tx_par = 1'b0;
               n.tx_pin = 1'b0;
            end
         TX_START:
            if (tx_edge)
            begin
               n.tx_st = TX_DATA;
               n.tx_bit = 3'h0;
               n.tx_pin = s.tx_sh[0];
               n.tx_par = s.tx_sh[0];
               n.tx_sh = s.tx_sh >> 1;
            end
         TX_DATA:
            if (tx_edge)
            begin
               if (s.tx_bit == nlast)
               begin
                  n.tx_bit = 3'h0;
                  n.tx_st = s.line_control_reg[LCR_PEN_BIT] ? TX_PAR : TX_STOP;
                  n.tx_pin = s.line_control_reg[LCR_PEN_BIT] ? (s.tx_par ^ !s.line_control_reg[LCR_EVEN_BIT]) : 1'b1;
               end
               else
               begin
                  n.tx_bit = s.tx_bit + 3'h1;
                  n.tx_pin = s.tx_sh[0];
                  n.tx_par = s.tx_par ^ s.tx_sh[0];
                  n.tx_sh = s.tx_sh >> 1;
               end
            end
         TX_PAR:
            if (tx_edge)
            begin
               n.tx_st = TX_STOP;
               n.tx_pin = 1'b1;
            end
         TX_STOP:
            if (tx_edge)
            begin
               if (s.line_control_reg[LCR_STOP_BIT] && s.tx_bit == 3'h0)
                  n.tx_bit = 3'h1;
               else
                  n.tx_st = TX_IDLE;
            end
         default:
            n.tx_st = TX_IDLE;
      endcase

      // receiver: two-flop synchroniser, then edge detect on the second
      n.rx_s1 = rx_pin;
      n.rx_s2 = s.rx_s1;
      n.rx_prev = s.rx_s2;
      if (s.rx_st != RX_IDLE && s.tick)
         n.rx_cnt = s.rx_cnt + 4'h1;
      case (s.rx_st)
         RX_IDLE:
            if (s.rx_prev && !s.rx_s2)
            begin
               n.rx_st = RX_START;
               n.rx_cnt = 4'h0;
            end
         RX_START:
            if (s.tick && s.rx_cnt == START_MID)
            begin
               n.rx_st = s.rx_s2 ? RX_IDLE : RX_DATA;
               n.rx_cnt = 4'h0;
               n.rx_bit = 3'h0;
               n.rx_par = 1'b0;
               n.rx_perr = 1'b0;
               n.rx_one = 1'b0;
            end
         RX_DATA:
            if (rx_edge)
            begin
               n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
               n.rx_par = s.rx_par ^ s.rx_s2;
               n.rx_one = s.rx_one | s.rx_s2;
               n.rx_bit = s.rx_bit + 3'h1;
               if (s.rx_bit == nlast)
                  n.rx_st = s.line_control_reg[LCR_PEN_BIT] ? RX_PAR : RX_STOP;
            end
         RX_PAR:
            if (rx_edge)
            begin
               n.rx_perr = s.rx_s2 ^ s.rx_par ^ !s.line_control_reg[LCR_EVEN_BIT];
               n.rx_one = s.rx_one | s.rx_s2;
               n.rx_st = RX_STOP;
            end
         RX_STOP:
            if (rx_edge)
            begin
               n.rx_st = RX_IDLE;
               rx_wdata.data = s.rx_sh >> (2'h3 - s.line_control_reg[1:0]);
               rx_wdata.par = s.rx_perr;
               rx_wdata.frame = !s.rx_s2;
               rx_wdata.brk = !s.rx_one && !s.rx_s2;
               if (rx_full)
                  n.overrun = 1'b1;
               else
                  rx_push = 1'b1;
            end
         default:
            n.rx_st = RX_IDLE;
      endcase

      // receive time-out; a crossing in the cycle of a read still sets
      if (rx_push || rx_pop || rx_count == '0)
         n.tmo_cnt = 11'h000;
      else if (s.tick && s.tmo_cnt != tmo_lim)
         n.tmo_cnt = s.tmo_cnt + 11'h001;
      if (s.tick && rx_count != '0 && s.tmo_cnt == tmo_lim - 11'h001 && !rx_push)
         n.tmo_flag = 1'b1;
      else if (rx_pop || rx_count == '0)
         n.tmo_flag = 1'b0;

      n.irq_pin = tmo_int || rda_int || thr_int;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.dll <= DLL_RST;
         s.divisor_high_reg <= DLM_RST;
         s.hreadyout <= 1'b1;
         s.tx_pin <= 1'b1;
         s.rx_s1 <= 1'b1;
         s.rx_s2 <= 1'b1;
         s.rx_prev <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   assign hreadyout = s.hreadyout;
   assign hrdata = s.hrdata;
   assign hresp = s.hresp;
   assign tx_pin = s.tx_pin;
   assign irq_pin = s.irq_pin;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_prescale_one: assert property (!s.modem_control_reg[MCR_PRESCALE_BIT] |-> pre_tick)
      else $error("prescaler not dividing by one");
   a_prescale_four: assert property ((s.modem_control_reg[MCR_PRESCALE_BIT] && pre_tick)
      ##1 s.modem_control_reg[MCR_PRESCALE_BIT] [*3] |-> !$past(pre_tick))
      else $error("prescaler not dividing by four");
   a_divisor_two: assert property ((s.tick && {s.divisor_high_reg, s.dll} == 16'h0002 && pre_tick
      && !s.modem_control_reg[MCR_PRESCALE_BIT] && !s.wr_pend) |=> !s.tick ##1 s.tick)
      else $error("divider period wrong");
   a_bit_sixteen: assert property ((s.tx_st != TX_IDLE && $changed(s.tx_st)
      && $past(s.tx_st) != TX_IDLE) |-> $past(s.tx_cnt) == BIT_LAST)
      else $error("bit period not sixteen ticks");
   a_start_low: assert property (s.tx_st == TX_START |-> !s.tx_pin)
      else $error("start bit not low");
   a_lsb_first: assert property (($past(s.tx_st) == TX_START && s.tx_st == TX_DATA)
      |-> s.tx_pin == $past(s.tx_sh[0]))
      else $error("first data bit not lsb");
   a_tx_push: assert property ((tx_push && !tx_pop && !tx_clr)
      |=> tx_count == $past(tx_count) + FIFO_CW'(1))
      else $error("write did not push");
   a_tx_empty: assert property (temt |-> (tx_count == '0 && s.tx_pin))
      else $error("transmitter empty too early");
   a_start_reject: assert property ((s.rx_st == RX_START && s.tick
      && s.rx_cnt == START_MID && s.rx_s2) |=> s.rx_st == RX_IDLE)
      else $error("false start accepted");
   a_rx_pop: assert property ((rx_pop && !rx_push && !rx_clr)
      |=> rx_count == $past(rx_count) - FIFO_CW'(1))
      else $error("data read did not advance fifo");
   a_tmo_data: assert property ($rose(s.tmo_flag) |-> $past(rx_count) != '0)
      else $error("time-out with empty receiver");
   a_bus_ready: assert property (addr_ok |=> s.hreadyout && !s.hresp)
      else $error("bus transfer not completed");

   c_tx_frame: cover property (s.tx_st == TX_STOP ##1 s.tx_st == TX_IDLE);
   c_rx_push: cover property (rx_push && rx_wdata.frame == 1'b0);
   c_rx_tmo: cover property ($rose(s.tmo_flag));
   c_overrun: cover property ($rose(s.overrun));

endmodule : ubt_core
`default_nettype wire

// ===== ubt_pkg.sv
// constants, types and helpers shared by the serial core and its fifo
// assumes one 100 MHz clock feeding both bus and serial logic
package ubt_pkg;

   // ------------------------------------------------------------
   // register offsets on the bus (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_IER = 8'h04;
   localparam logic [7:0] OFS_ISR_FCR = 8'h08;
   localparam logic [7:0] OFS_LCR = 8'h0c;
   localparam logic [7:0] OFS_MCR = 8'h10;
   localparam logic [7:0] OFS_LSR = 8'h14;
   localparam logic [7:0] OFS_DLL = 8'h18;
   localparam logic [7:0] OFS_DLM = 8'h1c;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   // ------------------------------------------------------------
   // reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] DLL_RST = 8'h01;
   localparam logic [7:0] DLM_RST = 8'h00;
   localparam int MCR_PRESCALE_BIT = 7;
   localparam int FCR_EN_BIT = 0;
   localparam int FCR_RXCLR_BIT = 1;
   localparam int FCR_TXCLR_BIT = 2;
   localparam int IER_RX_BIT = 0;
   localparam int IER_TX_BIT = 1;
   localparam int LCR_STOP_BIT = 2;
   localparam int LCR_PEN_BIT = 3;
   localparam int LCR_EVEN_BIT = 4;

   // ------------------------------------------------------------
   // counts
   // ------------------------------------------------------------
   localparam logic [1:0] PRE_LAST = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'hf;
   localparam logic [3:0] START_MID = 4'h7;
   localparam logic [2:0] DATA_LAST_MIN = 3'h4;
   localparam int BIT_TICKS = 16;
   localparam int BASE_BITS = 5;
   localparam int TMO_WORDS = 4;
   localparam int TMO_BITS = 12;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_CW = 5;

   // ------------------------------------------------------------
   // interrupt identification codes
   // ------------------------------------------------------------
   localparam logic [7:0] ISR_NONE = 8'h01;
   localparam logic [7:0] ISR_THRE = 8'h02;
   localparam logic [7:0] ISR_RDA = 8'h04;
   localparam logic [7:0] ISR_TMO = 8'h0c;
   localparam logic [7:0] ISR_FIFO = 8'hc0;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ubt_tx_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ubt_rx_t;

   // receive fifo entry: error tags above the byte
   typedef struct packed {
      logic brk;
      logic frame;
      logic par;
      logic [7:0] data;
   } ubt_rx_entry_t;

   function automatic logic [4:0] ubt_trig(input logic [1:0] sel);
      logic [4:0] lvl;
      lvl = 5'h01;
      case (sel)
         2'h1: lvl = 5'h04;
         2'h2: lvl = 5'h08;
         2'h3: lvl = 5'h0e;
         default: lvl = 5'h01;
      endcase
      return lvl;
   endfunction : ubt_trig

endpackage : ubt_pkg

// ===== ubt_fifo.sv
// synchronous fifo with count, used for both serial directions
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ubt_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic push,
   input wire logic [W-1:0] wdata,
   input wire logic pop,
   output logic [W-1:0] rdata,
   output logic [$clog2(DEPTH):0] count
);
   import ubt_pkg::*;
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("fifo depth must be a power of two of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ubt_fifo_state_t;

   ubt_fifo_state_t s;
   ubt_fifo_state_t n;
   logic [W-1:0] mem [DEPTH];
   logic do_push;
   logic do_pop;

   assign do_push = push && (s.cnt != (AW+1)'(DEPTH));
   assign do_pop = pop && (s.cnt != '0);
   assign rdata = mem[s.rp];
   assign count = s.cnt;

   always_comb
   begin
      n = s;
      if (clear)
      begin
         n = '0;
      end
      else
      begin
         if (do_push)
         begin
            n.wp = s.wp + 1'b1;
         end
         if (do_pop)
         begin
            n.rp = s.rp + 1'b1;
         end
         n.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   always_ff @(posedge clk)
   begin
      if (do_push && !clear)
      begin
         mem[s.wp] <= wdata;
      end
   end

   a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
      s.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");

endmodule : ubt_fifo
`default_nettype wire

// ===== ubt_remote.sv
// remote serial end: drives frames into the core, captures frames from it
// assumes 8 data bits, no parity, one stop; bit length in hclk cycles
`timescale 1ns/1ps
`default_nettype none
module ubt_remote (
   input wire logic hclk,
   input wire logic tx_line,
   output logic rx_line
);
   initial rx_line = 1'b1;

   // ------------------------------------------------------------
   // frame driver
   // ------------------------------------------------------------
   task automatic send(input logic [7:0] b, input int len);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
         repeat (len) @(posedge hclk) rx_line <= f[i];
   endtask : send

   // short low pulse, too brief to be a start bit
   task automatic glitch(input int n);
      repeat (n) @(posedge hclk) rx_line <= 1'b0;
      @(posedge hclk) rx_line <= 1'b1;
   endtask : glitch

   // ------------------------------------------------------------
   // frame capture: byte must have bit 0 set, start width in cycles
   // ------------------------------------------------------------
   task automatic recv(input int len, output logic [8:0] b, output int w);
      realtime t0;
      @(negedge tx_line);
      t0 = $realtime;
      @(posedge tx_line);
      w = int'(($realtime - t0) / 10.0);
      #(len * 5);
      // no wait after the last sample, so a back-to-back start edge is not missed
      for (int i = 0; i < 9; i++)
      begin
         b[i] = tx_line;
         if (i < 8)
            #(len * 10);
      end
   endtask : recv
endmodule : ubt_remote
`default_nettype wire

// ===== uart_baud_tx_rx_core_tb.sv
// self-checking bench: bus tasks, then reset, transmit, prescale, receive
// assumes one slave, so hready is the core's own hreadyout
`timescale 1ns/1ps
`default_nettype none
module uart_baud_tx_rx_core_tb;
   import ubt_pkg::*;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, rx_pin, tx_pin, irq_pin;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [8:0] got;
   int fails = 0;
   int checked = 0;
   int w;

   always #5 hclk = ~hclk;

   ubt_core u_ubt_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_pin(rx_pin),
      .tx_pin(tx_pin), .irq_pin(irq_pin));
   ubt_remote u_ubt_remote (.hclk(hclk), .tx_line(tx_pin), .rx_line(rx_pin));

   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask : chk

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(n, rd, e);
   endtask : rchk

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (30000) @(posedge hclk);
      fails++;
      give_verdict;
   end

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = SIZE_WORD;
      hwdata = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("dll", OFS_DLL, {24'h0, DLL_RST});
      rchk("dlm", OFS_DLM, {24'h0, DLM_RST});
      rchk("mcr", OFS_MCR, 32'h0);
      rchk("lsr idle", OFS_LSR, 32'h60);
      ahb(1'b1, OFS_IER, 32'h2);
      rchk("isr tx", OFS_ISR_FCR, {24'h0, ISR_THRE});
      chk("irq", {31'h0, irq_pin}, 32'h1);
      chk("hresp", {31'h0, hresp}, 32'h0);
      ahb(1'b1, OFS_IER, 32'h0);
      ahb(1'b1, OFS_LCR, 32'h3);
      $display("test reset done");
      ahb(1'b1, OFS_ISR_FCR, 32'h1);
      fork
         begin
            u_ubt_remote.recv(16, got, w);
            chk("tx byte0", {23'h0, got}, 32'h1a5);
            chk("bit width", 32'(w), 32'd16);
            u_ubt_remote.recv(16, got, w);
            chk("tx byte1", {23'h0, got}, 32'h137);
         end
         begin
            ahb(1'b1, OFS_DATA, 32'ha5);
            ahb(1'b1, OFS_DATA, 32'h37);
         end
      join
      repeat (20) @(posedge hclk);
      rchk("lsr tx done", OFS_LSR, 32'h60);
      ahb(1'b1, OFS_LCR, 32'h1b);
      fork
         u_ubt_remote.recv(16, got, w);
         ahb(1'b1, OFS_DATA, 32'ha5);
      join
      chk("tx even parity", {23'h0, got}, 32'h0a5);
      ahb(1'b1, OFS_LCR, 32'h3);
      $display("test transmit done");
      ahb(1'b1, OFS_MCR, 32'h80);
      ahb(1'b1, OFS_DLL, 32'h2);
      fork
         u_ubt_remote.recv(128, got, w);
         ahb(1'b1, OFS_DATA, 32'ha5);
      join
      chk("scaled width", 32'(w), 32'd128);
      rchk("mcr set", OFS_MCR, 32'h80);
      ahb(1'b1, OFS_MCR, 32'h0);
      ahb(1'b1, OFS_DLL, 32'h1);
      $display("test prescale done");
      u_ubt_remote.glitch(4);
      repeat (200) @(posedge hclk);
      rchk("lsr glitch", OFS_LSR, 32'h60);
      u_ubt_remote.send(8'h3c, 16);
      rchk("lsr rx", OFS_LSR, 32'h61);
      rchk("rx data", OFS_DATA, 32'h3c);
      rchk("lsr drained", OFS_LSR, 32'h60);
      $display("test receive done");
      ahb(1'b1, OFS_ISR_FCR, 32'h41);
      ahb(1'b1, OFS_IER, 32'h1);
      u_ubt_remote.send(8'h3c, 16);
      rchk("isr below trig", OFS_ISR_FCR, {24'h0, ISR_NONE | ISR_FIFO});
      repeat (720) @(posedge hclk);
      rchk("isr timeout", OFS_ISR_FCR, {24'h0, ISR_TMO | ISR_FIFO});
      chk("irq timeout", {31'h0, irq_pin}, 32'h1);
      rchk("rx data tmo", OFS_DATA, 32'h3c);
      rchk("isr cleared", OFS_ISR_FCR, {24'h0, ISR_NONE | ISR_FIFO});
      $display("test timeout done");
      give_verdict;
   end
endmodule : uart_baud_tx_rx_core_tb
`default_nettype wire
